/* File: pkg/aesp_pkg.sv */
package aesp_pkg;
  // Serial frame
  localparam int          FRAME_BITS   = 32;
  localparam int          CH_BITS_END  = 8;
  localparam int          CFG_BITS_END = 16;
  localparam logic [2:0]  HDR_ENABLE   = 3'h5;
  localparam int          CNT_W        = 6;
  // Field positions inside the captured bytes
  localparam int          CH_HDR_MSB   = 7;
  localparam int          CFG_EN_BIT   = 7;
  localparam int          CFG_TEMP_BIT = 6;
  localparam int          CFG_FA_BIT   = 5;
  localparam int          CFG_FB_BIT   = 4;
  localparam int          CFG_RATE_BIT = 3;
  // Reset values
  localparam logic [4:0]  CH_RESET     = 5'h00;
  localparam logic [3:0]  CFG_RESET    = 4'h0;
  // Timing
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          POR_TIME_NS   = 4000000;
  localparam int          POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CONV_CYCLES   = 400;
  localparam int          SCK_HALF      = 8;
  // Controller register offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_TX       = 8'h04;
  localparam logic [7:0]  OFS_RX       = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0c;
  localparam logic [7:0]  OFS_LEN      = 8'h10;
  // Controller field positions
  localparam int          CTRL_START   = 0;
  localparam int          CTRL_3WIRE   = 1;
  localparam int          ST_BUSY      = 0;
  localparam int          ST_DONE      = 1;
  localparam int          ST_EOC       = 2;
  localparam logic [5:0]  LEN_RESET    = 6'h20;

  typedef enum logic [1:0] {
    DEV_POR   = 2'b00,
    DEV_CONV  = 2'b01,
    DEV_SLEEP = 2'b10,
    DEV_IO    = 2'b11
  } aesp_dev_state_type;

  typedef enum logic [2:0] {
    HST_IDLE  = 3'b000,
    HST_SETUP = 3'b001,
    HST_WAIT  = 3'b010,
    HST_HIGH  = 3'b011,
    HST_LOW   = 3'b100,
    HST_END   = 3'b101
  } aesp_host_state_type;
endpackage

/* File: pkg/aesp_link_if.sv */
`timescale 1ns/1ps
interface aesp_link_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // Floating data line reads high through the bus pull-up
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev
  (
    input  cs_n,
    input  sck,
    input  sdi,
    output sdo,
    output sdo_oe
  );

  modport host
  (
    output cs_n,
    output sck,
    output sdi,
    input  sdo_line
  );
endinterface

/* File: logic/aesp_sync.sv */
`timescale 1ns/1ps
module aesp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Three stages; a bit changes once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk_sys or posedge reset)
    begin
      if (reset)
      begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        dout[i] <= 1'b0;
      end
      else
      begin
        s1_q[i] <= din[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i])
        begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* File: logic/aesp_dev.sv */
// Behaviour
// - Speed option halves conversion time, skips calibration
// - Result belongs to the conversion just finished
// - Temperature select converts sensor, mux unchanged
// - Temperature conversions always use normal rate
// - SCK high at CS fall selects internal clock
// - SDO released while CS high, flag or data bit otherwise
// - Flag high converting, low when asleep
// - Sleep after conversion; low power needs CS high
// - First SCK rise with CS low in sleep starts I/O, external clock mode only
// - New settings apply to the following conversion
// - SDO changes on SCK fall, host samples rise
// - 32nd SCK fall starts conversion, SDO high
// - CS rise mid-frame aborts, starts conversion
// - Abort before 8th fall keeps old channel
// - Configuration loads only after 16th fall
// - Power-on cycle ends, SCK picks clock mode
// - Three-wire host ties CS low, SCK low, raising CS only to end frames of any length other than 32 bits
// - CS low shows flag continuously outside I/O
// - Result loaded on flag fall, shifted by SCK
// - 32nd fall drives SDO high as next flag
// - Configuration needs header 101 and enable bit
`timescale 1ns/1ps
module aesp_dev #(
  parameter int POR_CYC  = aesp_pkg::POR_CYCLES,
  parameter int CONV_CYC = aesp_pkg::CONV_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  aesp_link_if.dev         link,
  input  wire logic [30:0] ext_code,
  input  wire logic [30:0] temp_code,
  output logic      [4:0]  mux_chan,
  output logic             temp_sensor_sel,
  output logic             rate_double_sel,
  output logic      [1:0]  reject_sel,
  output logic             conv_busy,
  output logic             low_power,
  output logic             int_clk_mode
);
  import aesp_pkg::*;

  localparam int CW = 24;

  initial
  begin
    if (POR_CYC < 1 || POR_CYC >= (1 << CW) || CONV_CYC < 2 || CONV_CYC >= (1 << CW))
    begin
      $error("aesp_dev: timing parameters out of range");
    end
  end

  typedef struct packed {
    aesp_dev_state_type st;
    logic               int_mode;
    logic               sdo;
    logic               cs_p;
    logic               sck_p;
    logic [31:0]        sr_out;
    logic [7:0]         sr_in;
    logic [7:0]         ch_cap;
    logic [7:0]         cfg_cap;
    logic [CNT_W-1:0]   fcnt;
    logic [4:0]         ch;
    logic [3:0]         cfg;
    logic [4:0]         ch_act;
    logic [3:0]         cfg_act;
    logic [CW-1:0]      cnt;
  } aesp_dev_reg_type;

  aesp_dev_reg_type q;
  aesp_dev_reg_type d;
  logic [2:0]       pin_s;
  logic             cs_s;
  logic             sck_s;
  logic             sdi_s;
  logic             sck_rise;
  logic             sck_fall;
  logic             cs_rise;
  logic             cs_fall;
  logic [CW-1:0]    conv_len;

  aesp_sync #(.WIDTH(3)) u_sync
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     ({~link.cs_n, link.sck, link.sdi}),
    .dout    (pin_s)
  );

  // Edges of the synchronised link pins; select passes inverted so that a
  // cleared synchroniser reads as deselected and the data line stays released
  assign cs_s     = ~pin_s[2];
  assign sck_s    = pin_s[1];
  assign sdi_s    = pin_s[0];
  assign sck_rise = sck_s & ~q.sck_p;
  assign sck_fall = ~sck_s & q.sck_p;
  assign cs_rise  = cs_s & ~q.cs_p;
  assign cs_fall  = ~cs_s & q.cs_p;

  // Conversion length from the active configuration
  always_comb
  begin
    conv_len = CW'(CONV_CYC);
    if (q.cfg_act[0] && !q.cfg_act[3])
    begin
      conv_len = CW'(CONV_CYC / 2);
    end
  end

  // Next state
  always_comb
  begin
    logic [CNT_W-1:0] nf;
    logic             commit;
    nf     = q.fcnt + CNT_W'(1);
    commit = 1'b0;
    d       = q;
    d.cs_p  = cs_s;
    d.sck_p = sck_s;
    if (cs_fall && q.st != DEV_POR)
    begin
      d.int_mode = sck_s;
    end
    case (q.st)
      DEV_POR:
      begin
        d.cnt = q.cnt + CW'(1);
        if (q.cnt == CW'(POR_CYC - 1))
        begin
          d.int_mode = sck_s;
          d.st       = DEV_CONV;
          d.cnt      = '0;
        end
      end
      DEV_CONV:
      begin
        d.cnt = q.cnt + CW'(1);
        if (q.cnt >= conv_len - CW'(1))
        begin
          // Fresh result from this conversion only, latched at flag fall
          d.st     = DEV_SLEEP;
          d.sr_out = {1'b0, q.cfg_act[3] ? temp_code : ext_code};
        end
      end
      DEV_SLEEP:
      begin
        if (!cs_s && sck_rise && !q.int_mode)
        begin
          d.st    = DEV_IO;
          d.sr_in = {q.sr_in[6:0], sdi_s};
          d.fcnt  = '0;
        end
      end
      default:
      begin
        if (sck_rise)
        begin
          d.sr_in = {q.sr_in[6:0], sdi_s};
        end
        if (cs_rise)
        begin
          if (q.fcnt == '0)
          begin
            d.st = DEV_SLEEP;
          end
          else
          begin
            commit = 1'b1;
          end
        end
        else if (sck_fall)
        begin
          d.fcnt   = nf;
          d.sr_out = {q.sr_out[30:0], 1'b0};
          if (nf == CNT_W'(CH_BITS_END))
          begin
            d.ch_cap = q.sr_in;
          end
          if (nf == CNT_W'(CFG_BITS_END))
          begin
            d.cfg_cap = q.sr_in;
          end
          if (nf == CNT_W'(FRAME_BITS))
          begin
            commit = 1'b1;
          end
        end
      end
    endcase
    if (commit)
    begin
      // Channel after 8 falls, configuration after 16 with header and enable
      if (d.fcnt >= CNT_W'(CH_BITS_END) && d.ch_cap[CH_HDR_MSB -: 3] == HDR_ENABLE)
      begin
        d.ch = d.ch_cap[4:0];
        if (d.fcnt >= CNT_W'(CFG_BITS_END) && d.cfg_cap[CFG_EN_BIT])
        begin
          d.cfg = {d.cfg_cap[CFG_TEMP_BIT], d.cfg_cap[CFG_FA_BIT],
                   d.cfg_cap[CFG_FB_BIT], d.cfg_cap[CFG_RATE_BIT]};
        end
      end
      d.st      = DEV_CONV;
      d.cnt     = '0;
      d.ch_act  = d.ch;
      d.cfg_act = d.cfg;
    end
    // Flag or data bit for the data line
    case (d.st)
      DEV_SLEEP: d.sdo = 1'b0;
      DEV_IO:    d.sdo = d.sr_out[31];
      default:   d.sdo = 1'b1;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      q         <= '0;
      q.st      <= DEV_POR;
      q.sdo     <= 1'b1;
      q.cs_p    <= 1'b1;
      q.ch      <= CH_RESET;
      q.cfg     <= CFG_RESET;
      q.ch_act  <= CH_RESET;
      q.cfg_act <= CFG_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // Link and user outputs
  assign link.sdo        = q.sdo;
  assign link.sdo_oe     = ~cs_s;
  assign mux_chan        = q.ch_act;
  assign temp_sensor_sel = q.cfg_act[3];
  assign rate_double_sel = q.cfg_act[0] & ~q.cfg_act[3];
  assign reject_sel      = q.cfg_act[2:1];
  assign conv_busy       = (q.st == DEV_CONV);
  assign low_power       = (q.st == DEV_SLEEP) & cs_s;
  assign int_clk_mode    = q.int_mode;
endmodule

/* File: logic/aesp_host.sv */
`timescale 1ns/1ps
module aesp_host #(
  parameter int HALF = aesp_pkg::SCK_HALF
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  aesp_link_if.host        link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import aesp_pkg::*;

  initial
  begin
    // The data line reaches sdo_s nine cycles after a clock fall
    if (HALF < 5 || HALF > 255)
    begin
      $error("aesp_host: HALF out of range");
    end
  end

  typedef struct packed {
    aesp_host_state_type st;
    logic                three_wire;
    logic                done;
    logic                cs_n;
    logic                sck;
    logic [31:0]         tx;
    logic [31:0]         rx;
    logic [5:0]          len;
    logic [5:0]          bits;
    logic [7:0]          div;
  } aesp_host_reg_type;

  aesp_host_reg_type q;
  aesp_host_reg_type d;
  logic              sdo_s;
  logic              sdo_n_s;
  logic              wr;
  logic              tick;

  aesp_sync #(.WIDTH(1)) u_sync
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (~link.sdo_line),
    .dout    (sdo_n_s)
  );

  // Inverted through the synchroniser so that reset reads as the pulled-up idle level
  assign sdo_s   = ~sdo_n_s;

  // Zero-wait APB access
  assign wr      = psel & penable & pwrite;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~(paddr == OFS_CTRL || paddr == OFS_TX ||
                   paddr == OFS_RX || paddr == OFS_STATUS || paddr == OFS_LEN);
  assign tick    = (q.div == 8'(HALF - 1));

  // Read mux
  always_comb
  begin
    prdata = '0;
    if (paddr == OFS_CTRL)
    begin
      prdata[CTRL_3WIRE] = q.three_wire;
    end
    else if (paddr == OFS_TX)
    begin
      prdata = q.tx;
    end
    else if (paddr == OFS_RX)
    begin
      prdata = q.rx;
    end
    else if (paddr == OFS_STATUS)
    begin
      prdata[ST_BUSY] = (q.st != HST_IDLE);
      prdata[ST_DONE] = q.done;
      prdata[ST_EOC]  = sdo_s;
    end
    else if (paddr == OFS_LEN)
    begin
      prdata[5:0] = q.len;
    end
  end

  // Next state
  always_comb
  begin
    d     = q;
    d.div = (q.st == HST_IDLE || tick) ? 8'h00 : q.div + 8'h01;
    if (wr && paddr == OFS_TX && q.st == HST_IDLE)
    begin
      d.tx = pwdata;
    end
    if (wr && paddr == OFS_LEN && q.st == HST_IDLE && pwdata[5:0] != 6'h00)
    begin
      d.len = pwdata[5:0];
    end
    if (wr && paddr == OFS_STATUS && pwdata[ST_DONE])
    begin
      d.done = 1'b0;
    end
    if (wr && paddr == OFS_CTRL && q.st == HST_IDLE)
    begin
      d.three_wire = pwdata[CTRL_3WIRE];
      d.cs_n       = ~pwdata[CTRL_3WIRE];
      if (pwdata[CTRL_START])
      begin
        d.st   = HST_SETUP;
        d.cs_n = 1'b0;
        d.bits = '0;
      end
    end
    case (q.st)
      HST_SETUP:
      begin
        if (tick)
        begin
          d.st = HST_WAIT;
        end
      end
      HST_WAIT:
      begin
        if (tick && !sdo_s)
        begin
          d.st  = HST_HIGH;
          d.sck = 1'b1;
        end
      end
      HST_HIGH:
      begin
        if (tick)
        begin
          d.st   = HST_LOW;
          d.sck  = 1'b0;
          d.bits = q.bits + 6'h01;
          d.tx   = {q.tx[30:0], 1'b0};
        end
      end
      HST_LOW:
      begin
        if (tick)
        begin
          if (q.bits == q.len)
          begin
            d.st   = HST_END;
            d.cs_n = ~q.three_wire | (q.len != 6'(FRAME_BITS));
          end
          else
          begin
            d.st  = HST_HIGH;
            d.sck = 1'b1;
          end
        end
      end
      HST_END:
      begin
        if (tick)
        begin
          d.st   = HST_IDLE;
          d.done = 1'b1;
          d.cs_n = ~q.three_wire;
        end
      end
      default:
      begin
      end
    endcase
    // Bit that stood at the rising edge, taken as the high phase ends; the
    // synchronised line lags a fall by nine cycles, too late for the next rise
    if (q.st == HST_HIGH && d.st == HST_LOW)
    begin
      d.rx = {q.rx[30:0], sdo_s};
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      q      <= '0;
      q.st   <= HST_IDLE;
      q.cs_n <= 1'b1;
      q.sck  <= 1'b0;
      q.len  <= LEN_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.cs_n = q.cs_n;
  assign link.sck  = q.sck;
  assign link.sdi  = q.tx[31];
endmodule

/* File: tb/aesp_link_asserts.sv */
`timescale 1ns/1ps
module aesp_link_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic [5:0] falls_q;
  logic       sck_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Counts clock falls within one frame
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      falls_q <= 6'h00;
      sck_q   <= 1'b0;
    end
    else
    begin
      sck_q <= sck;
      if (cs_n)
      begin
        falls_q <= 6'h00;
      end
      else if (sck_q && !sck)
      begin
        falls_q <= falls_q + 6'h01;
      end
      else if (falls_q == 6'h20)
      begin
        falls_q <= 6'h00;
      end
    end
  end

  // The 32nd fall of a frame
  sequence s_last_fall;
    $fell(sck) && falls_q == 6'h1f;
  endsequence

  property p_oe_off;    cs_n [*6] |-> !sdo_oe; endproperty
  property p_oe_on;     !cs_n [*6] |-> sdo_oe; endproperty
  property p_sdo_hold;  sck [*6] |-> $stable(sdo); endproperty
  property p_sdi_hold;  sck && $past(sck) |-> $stable(sdi); endproperty
  property p_cs_fall;   $fell(cs_n) |-> !sck; endproperty
  property p_cs_rise;   $rose(cs_n) |-> !sck; endproperty
  property p_first_rise; $rose(sck) && falls_q == 6'h00 |-> !sdo; endproperty
  property p_end_flag;  s_last_fall |-> ##[2:8] sdo; endproperty

  a_oe_off: assert property (p_oe_off)
    else $error("data line driven while deselected");
  a_oe_on: assert property (p_oe_on)
    else $error("data line released while selected");
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("data changed while clock high");
  a_sdi_hold: assert property (p_sdi_hold)
    else $error("input data changed while clock high");
  a_cs_fall: assert property (p_cs_fall)
    else $error("select fell with clock high");
  a_cs_rise: assert property (p_cs_rise)
    else $error("select rose with clock high");
  a_first_rise: assert property (p_first_rise)
    else $error("frame began while flag high");
  a_end_flag: assert property (p_end_flag)
    else $error("flag not raised after last fall");
endmodule

/* File: tb/adc_ext_clock_serial_port_tb_top.sv */
`timescale 1ns/1ps
module adc_ext_clock_serial_port_tb_top;
  import aesp_pkg::*;
  localparam int CONV = 40;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [30:0] ext_code = 31'h1234abc;
  logic [30:0] temp_code = 31'h0a5c3e1;
  logic [4:0]  mux_chan;
  logic        temp_sensor_sel;
  logic        rate_double_sel;
  logic [1:0]  reject_sel;
  logic        conv_busy;
  logic        low_power;
  logic        int_clk_mode;
  logic        int_clk_mode2;
  logic        tw = 1'b0;
  logic [31:0] r;
  logic        e;
  int          mismatches = 0;
  int          tests_run = 0;
  int          run_len = 0;
  int          last_len = 0;
  int          len_fast;
  aesp_link_if link ();
  aesp_link_if link2 ();

  aesp_dev #(.POR_CYC(50), .CONV_CYC(CONV)) aesp_dev_i (.clk_sys(clk_sys), .reset(reset),
    .link(link), .ext_code(ext_code), .temp_code(temp_code), .mux_chan(mux_chan),
    .temp_sensor_sel(temp_sensor_sel), .rate_double_sel(rate_double_sel),
    .reject_sel(reject_sel), .conv_busy(conv_busy), .low_power(low_power),
    .int_clk_mode(int_clk_mode));
  // Second device whose pins the bench drives directly
  aesp_dev #(.POR_CYC(50), .CONV_CYC(CONV)) aesp_dev_i2 (.clk_sys(clk_sys), .reset(reset),
    .link(link2), .ext_code(ext_code), .temp_code(temp_code), .mux_chan(),
    .temp_sensor_sel(), .rate_double_sel(), .reject_sel(), .conv_busy(), .low_power(),
    .int_clk_mode(int_clk_mode2));
  aesp_host #(.HALF(8)) aesp_host_i (.clk_sys(clk_sys), .reset(reset), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  aesp_link_asserts aesp_link_asserts_i (.clk_sys(clk_sys), .reset(reset),
    .cs_n(link.cs_n), .sck(link.sck), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));

  // Clock
  always #2.5 clk_sys = ~clk_sys;

  // Length of the latest conversion
  always @(posedge clk_sys)
  begin
    if (conv_busy === 1'b1) run_len <= run_len + 1;
    else
    begin
      if (run_len != 0) last_len <= run_len;
      run_len <= 0;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic hang;
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    print_verdict();
  endtask

  // One bus transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      if (++n > 20) hang();
      @(posedge clk_sys);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  function automatic logic [31:0] word(input logic [4:0] ch, input logic [4:0] cfg);
    return {3'b101, ch, cfg, 19'h0};
  endfunction

  // Frame, then settings checks while converting and a sleep check once the conversion ends
  task automatic row(input logic [31:0] tx, input logic [5:0] len, input logic [4:0] ch,
                     input logic [3:0] cfg, input logic [31:0] rx_x);
    int n;
    n = 0;
    apb(1'b1, OFS_TX, tx);
    apb(1'b1, OFS_LEN, {26'h0, len});
    apb(1'b1, OFS_CTRL, {30'h0, tw, 1'b1});
    r = 32'h0;
    while (r[ST_DONE] !== 1'b1)
    begin
      if (++n > 400) hang();
      apb(1'b0, OFS_STATUS, 32'h0);
    end
    chk(conv_busy, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h2);
    apb(1'b0, OFS_RX, 32'h0);
    if (len == 6'h20) chk(r, rx_x);
    chk(mux_chan, ch);
    chk({temp_sensor_sel, rate_double_sel, reject_sel}, cfg);
    n = 0;
    while (conv_busy !== 1'b0)
    begin
      if (++n > 200) hang();
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
    @(posedge clk_sys);
    chk(low_power, !tw);
  endtask

  // Main sequence
  initial
  begin
    link2.cs_n <= 1'b1;
    link2.sck <= 1'b1;
    link2.sdi <= 1'b0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (120) @(posedge clk_sys);
    chk(int_clk_mode, 1'b0);
    chk(int_clk_mode2, 1'b1);
    chk({mux_chan, temp_sensor_sel, rate_double_sel, reject_sel}, 9'h0);
    chk(link2.sdo_oe, 1'b0);
    link2.sck <= 1'b0;
    repeat (4) @(posedge clk_sys);
    link2.cs_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(int_clk_mode2, 1'b0);
    chk(link2.sdo_oe, 1'b1);
    link2.cs_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    link2.sck <= 1'b1;
    repeat (4) @(posedge clk_sys);
    link2.cs_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(int_clk_mode2, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1'b1);
    apb(1'b0, OFS_LEN, 32'h0);
    chk(r, {26'h0, LEN_RESET});
    row(word(5'h13, 5'h13), 6'h20, 5'h13, 4'h5, {1'b0, ext_code});
    len_fast = last_len;
    row(word(5'h05, 5'h19), 6'h20, 5'h05, 4'h8, {1'b0, ext_code});
    chk(last_len - len_fast, CONV / 2);
    row(word(5'h05, 5'h10), 6'h20, 5'h05, 4'h0, {1'b0, temp_code});
    row(word(5'h1f, 5'h1f), 6'h07, 5'h05, 4'h0, 32'h0);
    row(word(5'h0a, 5'h1f), 6'h0c, 5'h0a, 4'h0, 32'h0);
    row(word(5'h0c, 5'h0d), 6'h20, 5'h0c, 4'h0, {1'b0, ext_code});
    row({3'b010, 5'h03, 5'h10, 19'h0}, 6'h20, 5'h0c, 4'h0, {1'b0, ext_code});
    row(word(5'h0c, 5'h14), 6'h10, 5'h0c, 4'h2, 32'h0);
    chk(last_len, CONV);
    tw = 1'b1;
    row(word(5'h07, 5'h10), 6'h20, 5'h07, 4'h0, {1'b0, ext_code});
    chk(link.cs_n, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r[ST_EOC], 1'b0);
    row(word(5'h02, 5'h10), 6'h20, 5'h02, 4'h0, {1'b0, ext_code});
    print_verdict();
  end
endmodule
